/* File: src/sacc_top.sv */
// Conversion control for an eight-channel 10-bit successive
// approximation converter, with a Wishbone classic register slave.
// Assumes: one 25 MHz clock, synchronous reset, comparator and start
// pin asynchronous, idle and power-down levels from on-chip logic.
//
// Added by the designer: the Wishbone register port.
`default_nettype none

// How it works
// - Full conversion takes fifty machine cycles, ten bits
// - Fast mode: twenty-four cycles, eight-bit result
// - Idle keeps converter on only if enabled
// - External edge starts only when enabled
// - Pin edge seen at cycle end, starts next
// - Software start begins at following machine cycle
// - Start command and busy status are separate
// - Two init cycles; busy set after first
// - Eight sampling cycles (six in fast mode) before approximation
// - Top bit first, keep if above, descend
// - Four machine cycles per bit, two in fast mode
// - Upper bits high register, two low in control
// - Done set, busy cleared at completion
// - Three-bit code selects one of eight inputs
// - Channel changes only when done and busy low
// - Starts ignored while converting
// - Idle or power-down aborts; results kept
// - Busy without done blocks new start
// - Done flag blocks start until cleared
// - Clearing done with start may start
// - Hardware never clears done flag
// - Software may clear done, never set
module sacc_top
   import sacc_pkg::*;
(
   input wire logic ref_clk,        // System clock, 25 MHz
   input wire logic rst,            // Synchronous reset, active high
   input wire logic wb_cyc_i,       // Wishbone cycle
   input wire logic wb_stb_i,       // Wishbone strobe
   input wire logic wb_we_i,        // Wishbone write enable
   input wire logic [11:0] wb_adr_i, // Wishbone byte address
   input wire logic [3:0] wb_sel_i, // Wishbone byte lanes
   input wire logic [31:0] wb_dat_i, // Wishbone write data
   output logic [31:0] wb_dat_o,    // Wishbone read data
   output logic wb_ack_o,           // Wishbone acknowledge
   input wire logic idle_mode,      // Chip in idle mode
   input wire logic power_down,     // Chip in power-down mode
   input wire logic ext_start_pin,  // External start, asynchronous
   input wire logic comp_in,        // Comparator, input above DAC
   output logic [9:0] dac_voltage,  // Trial code to the ladder DAC
   output logic [2:0] analog_port,  // Selected analog input
   output logic sample_en,          // Sample switch closed
   output logic adc_powered,        // Converter supply on
   output logic conv_busy,          // Busy status flag
   output logic conv_done           // Completion flag, interrupt level
);

   // ---------------------------------------------------------------
   // Types
   // ---------------------------------------------------------------
   typedef enum logic [1:0] {
      SEQ_IDLE,
      SEQ_INIT,
      SEQ_SAMPLE,
      SEQ_CONVERT
   } sacc_seq_t;

   typedef struct packed {
      // Sequencing
      sacc_seq_t seq;       // Sequencer state
      logic [5:0] cnt;      // Machine cycles in phase
      logic cmd;            // Start command flip-flop
      logic busy;           // Busy status flag
      logic done;           // Completion flag
      // Register fields
      logic ext_en;         // ext_start_enable
      logic [2:0] chan;     // Channel code
      logic [1:0] res_lo;   // result_bit1, result_bit0
      logic [7:0] res_hi;   // result_high_reg
      logic mode8;          // eight_bit_mode_sel
      logic idle_act;       // adc_idle_active
      logic conv8;          // Mode latched at start
      // Synchronisers
      logic ext_s1;         // Start pin sync stage one
      logic ext_s2;         // Start pin sync stage two
      logic ext_prev;       // Pin level at previous cycle end
      logic cmp_s1;         // Comparator sync stage one
      logic cmp_s2;         // Comparator sync stage two
      // Output drivers
      logic ack;            // Bus acknowledge
      logic [31:0] dat;     // Bus read data
      logic samp;           // Sample switch
      logic pwr;            // Converter supply
   } sacc_regs_t;

   sacc_regs_t r;      // Current state
   sacc_regs_t next_r; // Next state

   // ---------------------------------------------------------------
   // Submodules
   // ---------------------------------------------------------------
   logic mc_strobe;      // End of machine cycle
   logic sar_load;       // Start approximation
   logic sar_decide;     // Latch decision
   logic [9:0] sar_code; // Approximation register
   logic sar_last;       // Final bit under test

   // Machine-cycle strobe from the system clock
   sacc_mcyc_div u_div (
      .ref_clk(ref_clk),
      .rst(rst),
      .mc_strobe(mc_strobe)
   );

   // Approximation register
   sacc_sar u_sar (
      .ref_clk(ref_clk),
      .rst(rst),
      .load(sar_load),
      .decide(sar_decide),
      .comp(r.cmp_s2),
      .mode8(r.conv8),
      .code(sar_code),
      .last(sar_last)
   );

   // ---------------------------------------------------------------
   // Control logic
   // ---------------------------------------------------------------
   // Decode results
   logic bus_req;     // New request awaiting answer
   logic bus_wr;      // Write takes effect this edge
   logic ctrl_wr;     // Write to control register
   logic aux_wr;      // Write to aux register
   logic conv_off;    // Converter held off
   logic ext_edge;    // Qualified pin rising edge
   logic sw_start;    // Accepted software start
   logic [5:0] phase_len; // Length of current phase
   logic [7:0] ctrl_rd;   // Control register readback
   logic [9:0] idx;       // Word index

   // Bus decode, start qualification and sequencing
   always_comb begin
      next_r = r;
      sar_load = 1'b0;
      sar_decide = 1'b0;
      idx = wb_adr_i[11:2];
      // Request seen once
      bus_req = wb_cyc_i && wb_stb_i && !r.ack;
      bus_wr = wb_cyc_i && wb_stb_i && r.ack && wb_we_i && wb_sel_i[0];
      ctrl_wr = bus_wr && (idx == ADC_CTRL_IDX);
      aux_wr = bus_wr && (idx == AUX_CTRL_IDX);
      ctrl_rd = {r.res_lo, r.ext_en, r.done, r.busy, r.chan};

      // Converter off in power-down, or in idle unless enabled
      conv_off = power_down || (idle_mode && !r.idle_act);
      phase_len = 6'h00;

      // Synchronisers for asynchronous inputs
      next_r.ext_s1 = ext_start_pin;
      next_r.ext_s2 = r.ext_s1;
      // Same for comparator
      next_r.cmp_s1 = comp_in;
      next_r.cmp_s2 = r.cmp_s1;

      // Bus answer: ack one cycle after request, drop after one
      next_r.ack = bus_req;
      if (bus_req) begin
         // Read mux
         if (idx == ADC_CTRL_IDX) begin
            next_r.dat = {24'h000000, ctrl_rd};
         end else if (idx == RES_HIGH_IDX) begin
            next_r.dat = {24'h000000, r.res_hi};
         end else if (idx == AUX_CTRL_IDX) begin
            next_r.dat = {24'h000000, r.mode8, r.idle_act, 6'h00};
         end else begin
            next_r.dat = 32'h00000000; // Unmapped reads zero
         end
      end

      // Aux register writes
      if (aux_wr) begin
         next_r.mode8 = wb_dat_i[AUX_MODE8_BIT];
         next_r.idle_act = wb_dat_i[AUX_IDLE_BIT];
      end

      // Control register writes
      sw_start = 1'b0;
      if (ctrl_wr) begin
         // Start mode
         next_r.ext_en = wb_dat_i[CTRL_EXT_BIT];
         // Zero clears, one ignored
         if (!wb_dat_i[CTRL_DONE_BIT]) begin
            next_r.done = 1'b0;
         end
         // Channel lock
         if (!r.done && !r.busy) begin
            next_r.chan = wb_dat_i[CTRL_CHAN_LSB +: 3];
         end

         // Start blocked by busy, pending command or a done flag this write does not clear
         sw_start = wb_dat_i[CTRL_START_BIT] && !r.busy && !r.cmd
                    && (r.seq == SEQ_IDLE) && !conv_off
                    && (!r.done || !wb_dat_i[CTRL_DONE_BIT]);
         // Runs at next strobe
         if (sw_start) begin
            next_r.cmd = 1'b1;
         end
      end

      // Pin rising edge judged at the end of each machine cycle
      ext_edge = 1'b0;
      if (mc_strobe) begin
         next_r.ext_prev = r.ext_s2;
         // Enabled, rising, quiet
         ext_edge = r.ext_en && r.ext_s2 && !r.ext_prev
                    && !r.cmd && !r.busy && !r.done
                    && (r.seq == SEQ_IDLE) && !conv_off;
      end

      // Phase lengths for the latched resolution
      unique case (r.seq)
         SEQ_INIT: begin
            phase_len = INIT_MC;
         end
         SEQ_SAMPLE: begin
            phase_len = r.conv8 ? SAMPLE_MC_8 : SAMPLE_MC_10;
         end
         SEQ_CONVERT: begin
            phase_len = r.conv8 ? BIT_MC_8 : BIT_MC_10;
         end
         // No phase
         SEQ_IDLE: begin
            phase_len = 6'h00;
         end
      endcase

      // Sequencer, advancing only at machine-cycle ends
      if (mc_strobe) begin
         unique case (r.seq)
            SEQ_IDLE: begin
               // Pending software command or a fresh pin edge
               if (r.cmd || ext_edge) begin
                  next_r.cmd = 1'b1;
                  next_r.seq = SEQ_INIT;
                  next_r.cnt = 6'h00;
                  next_r.conv8 = r.mode8;
               end
            end

            // Initiation
            SEQ_INIT: begin
               next_r.cnt = r.cnt + 6'h01;
               // First cycle over
               if (r.cnt == 6'h00) begin
                  next_r.busy = 1'b1;
                  next_r.cmd = 1'b0;
               end
               if (r.cnt == phase_len - 6'h01) begin
                  next_r.seq = SEQ_SAMPLE;
                  next_r.cnt = 6'h00;
                  next_r.samp = 1'b1;
               end
            end

            // Sampling
            SEQ_SAMPLE: begin
               next_r.cnt = r.cnt + 6'h01;
               if (r.cnt == phase_len - 6'h01) begin
                  next_r.seq = SEQ_CONVERT;
                  next_r.cnt = 6'h00;
                  next_r.samp = 1'b0;
                  // Load top trial
                  sar_load = 1'b1;
               end
            end

            // Bit steps
            SEQ_CONVERT: begin
               next_r.cnt = r.cnt + 6'h01;
               if (r.cnt == phase_len - 6'h01) begin
                  // Decision at the end of the step's last cycle
                  sar_decide = 1'b1;
                  next_r.cnt = 6'h00;
                  // Result out
                  if (sar_last) begin
                     next_r.seq = SEQ_IDLE;
                     next_r.busy = 1'b0;
                     next_r.done = 1'b1;
                     if (r.conv8) begin
                        // Bit 2 still trial
                        next_r.res_hi = {sar_code[9:3], r.cmp_s2};
                        next_r.res_lo = 2'h0;
                     end else begin
                        next_r.res_hi = sar_code[9:2];
                        next_r.res_lo = {sar_code[1], r.cmp_s2};
                     end
                  end
               end
            end
         endcase
      end

      // Idle or power-down abort; finished results stay untouched
      if (conv_off) begin
         next_r.seq = SEQ_IDLE;
         next_r.cnt = 6'h00;
         next_r.cmd = 1'b0;
         next_r.busy = 1'b0;
         next_r.samp = 1'b0;
         sar_load = 1'b0;
         sar_decide = 1'b0;
      end

      // Supply
      next_r.pwr = !conv_off;
   end

   // Register state; reset returns to idle with flags clear
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         r <= '0;
         // Register resets
         r.res_hi <= RES_HIGH_RESET;
         r.chan <= CTRL_RESET[2:0];
         r.mode8 <= AUX_RESET[AUX_MODE8_BIT];
         r.idle_act <= AUX_RESET[AUX_IDLE_BIT];
      end else begin
         r <= next_r;
      end
   end

   // ---------------------------------------------------------------
   // Outputs, all from flip-flops
   // ---------------------------------------------------------------
   assign wb_dat_o = r.dat;
   assign wb_ack_o = r.ack;

   // Analog side
   assign dac_voltage = sar_code;
   assign analog_port = r.chan;
   assign sample_en = r.samp;
   assign adc_powered = r.pwr;

   // Flags
   assign conv_busy = r.busy;
   assign conv_done = r.done;

endmodule // sacc_top

`default_nettype wire

/* File: src/sacc_pkg.sv */
// Package for the converter control block: register indices, field
// positions, reset values, sequencing counts and shared helpers.
// Assumes a single 25 MHz clock and a Wishbone classic register bus.
`default_nettype none

package sacc_pkg;

   // ---------------------------------------------------------------
   // Register indices (byte address is four times the index)
   // ---------------------------------------------------------------
   localparam logic [9:0] ADC_CTRL_IDX = 10'h0c5; // adc_control
   localparam logic [9:0] RES_HIGH_IDX = 10'h0c6; // result_high_reg
   localparam logic [9:0] AUX_CTRL_IDX = 10'h0c7; // aux_ctrl_reg

   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int CTRL_RES1_BIT = 7;  // result_bit1
   localparam int CTRL_RES0_BIT = 6;  // result_bit0
   localparam int CTRL_EXT_BIT = 5;   // ext_start_enable
   localparam int CTRL_DONE_BIT = 4;  // conv_done_flag
   localparam int CTRL_START_BIT = 3; // conv_start_flag
   localparam int CTRL_CHAN_LSB = 0;  // chan_sel_bit2..0
   localparam int AUX_MODE8_BIT = 7;  // eight_bit_mode_sel
   localparam int AUX_IDLE_BIT = 6;   // adc_idle_active

   // ---------------------------------------------------------------
   // Reset values
   // ---------------------------------------------------------------
   localparam logic [7:0] CTRL_RESET = 8'h00;
   localparam logic [7:0] AUX_RESET = 8'h00;
   localparam logic [7:0] RES_HIGH_RESET = 8'h00;

   // ---------------------------------------------------------------
   // Timing counts
   // ---------------------------------------------------------------
   localparam logic [3:0] MCYC_CLKS = 4'hc;    // Clocks per machine cycle
   localparam logic [5:0] INIT_MC = 6'h02;     // Initiation cycles
   localparam logic [5:0] SAMPLE_MC_10 = 6'h08; // Sampling, full mode
   localparam logic [5:0] SAMPLE_MC_8 = 6'h06;  // Sampling, fast mode
   localparam logic [5:0] BIT_MC_10 = 6'h04;    // Cycles per bit, full
   localparam logic [5:0] BIT_MC_8 = 6'h02;     // Cycles per bit, fast
   localparam logic [9:0] SAR_TOP = 10'h200;    // Only top bit set
   localparam logic [3:0] SAR_TOP_BIT = 4'h9;   // Pointer of top bit

   // Lowest bit under test for the selected resolution
   function automatic logic [3:0] sacc_low_bit(input logic mode8);
      sacc_low_bit = mode8 ? 4'h2 : 4'h0;
   endfunction

endpackage

`default_nettype wire

/* File: src/sacc_mcyc_div.sv */
// Machine-cycle strobe divider: one-cycle pulse every MCYC_CLKS clocks.
// Assumes the same clock and synchronous reset as the control block.
`default_nettype none

module sacc_mcyc_div
   import sacc_pkg::*;
(
   input wire logic ref_clk, // System clock
   input wire logic rst,     // Synchronous reset, active high
   output logic mc_strobe    // End of machine cycle pulse
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [3:0] cnt; // Clock count within machine cycle
      logic strobe;    // Registered pulse
   } sacc_div_t;

   sacc_div_t r;      // Current state
   sacc_div_t next_r; // Next state

   // Count and fire on the last clock of a machine cycle
   always_comb begin
      next_r = r;
      next_r.strobe = 1'b0;
      if (r.cnt == MCYC_CLKS - 4'h1) begin
         next_r.cnt = 4'h0;
         next_r.strobe = 1'b1;
      end else begin
         next_r.cnt = r.cnt + 4'h1;
      end
   end

   // Register state
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign mc_strobe = r.strobe;

endmodule // sacc_mcyc_div

`default_nettype wire

/* File: src/sacc_sar.sv */
// Successive approximation register with bit pointer.
// Assumes load and decide come from the sequencer on machine-cycle ends.
`default_nettype none

module sacc_sar
   import sacc_pkg::*;
(
   input wire logic ref_clk,     // System clock
   input wire logic rst,         // Synchronous reset, active high
   input wire logic load,        // Start approximation
   input wire logic decide,      // Latch comparator for bit under test
   input wire logic comp,        // Input above DAC voltage
   input wire logic mode8,       // Fast eight-bit mode
   output logic [9:0] code,      // Trial code to the DAC
   output logic last             // Bit under test is the final one
);

   // ---------------------------------------------------------------
   // State
   // ---------------------------------------------------------------
   typedef struct packed {
      logic [9:0] code; // Approximation register
      logic [3:0] ptr;  // Bit pointer
   } sacc_sar_t;

   sacc_sar_t r;      // Current state
   sacc_sar_t next_r; // Next state

   // Load top bit, then keep or clear and move to next lower bit
   always_comb begin
      next_r = r;
      if (load) begin
         next_r.code = SAR_TOP;
         next_r.ptr = SAR_TOP_BIT;
      end else if (decide) begin
         if (!comp) begin
            next_r.code[r.ptr] = 1'b0;
         end
         if (r.ptr != sacc_low_bit(mode8)) begin
            next_r.ptr = r.ptr - 4'h1;
            next_r.code[r.ptr - 4'h1] = 1'b1;
         end
      end
   end

   // Register state
   always_ff @(posedge ref_clk) begin
      if (rst) begin
         r <= '0;
      end else begin
         r <= next_r;
      end
   end

   assign code = r.code;
   assign last = (r.ptr == sacc_low_bit(mode8));

endmodule // sacc_sar

`default_nettype wire

/* File: tb/sacc_comp_model.sv */
// Comparator and input multiplexer model facing the converter control.
// Assumes eight fixed channel levels from the bench and one clock.
`default_nettype none

module sacc_comp_model (
   input wire logic ref_clk,           // Clock for the unpowered pattern
   input wire logic adc_powered,       // Converter supply on
   input wire logic [9:0] dac_voltage, // Trial code
   input wire logic [2:0] analog_port, // Selected channel
   input wire logic [9:0] vin [8],     // Channel levels
   output logic comp_in                // Input above trial code
);
   timeunit 1ns;
   timeprecision 1ps;
   logic junk = 1'b0; // Changing output while unpowered

   // Meaningless output toggles while unpowered
   always_ff @(posedge ref_clk) begin
      junk <= ~junk;
   end

   // Selected input against trial voltage, strictly greater
   assign comp_in = adc_powered ? (vin[analog_port] > dac_voltage) : junk;
endmodule // sacc_comp_model

`default_nettype wire

/* File: tb/sacc_top_assertions.sv */
// Timing checks for the converter control, watching top-level ports.
// Assumes machine cycles of twelve clocks and a bind from the bench.
`default_nettype none

module sacc_top_assertions
   import sacc_pkg::*;
(
   input wire logic ref_clk,
   input wire logic rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [11:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   input wire logic wb_ack_o,
   input wire logic power_down,
   input wire logic [9:0] dac_voltage,
   input wire logic [2:0] analog_port,
   input wire logic sample_en,
   input wire logic adc_powered,
   input wire logic conv_busy,
   input wire logic conv_done
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [9:0] bcnt; // Cycles busy stayed high
   logic [9:0] scnt; // Cycles sampling lasted
   logic clr_wr;     // Control write clearing done

   assign clr_wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o && wb_sel_i[0]
      && wb_adr_i[11:2] == ADC_CTRL_IDX && !wb_dat_i[CTRL_DONE_BIT];

   // Run lengths of busy and sampling
   always_ff @(posedge ref_clk) begin
      bcnt <= (rst || !conv_busy) ? 10'h000 : bcnt + 10'h001;
      scnt <= (rst || !sample_en) ? 10'h000 : scnt + 10'h001;
   end

   default clocking @(posedge ref_clk); endclocking
   default disable iff (rst);

   // ----------------------------------------------------------
   // Checks
   // ----------------------------------------------------------
   done_hold_a: assert property ($fell(conv_done) |-> $past(clr_wr))
      else $error("done flag fell without a clearing write");
   conv_time_a: assert property ($rose(conv_done) |-> $fell(conv_busy)
      && (bcnt == 10'h24c || bcnt == 10'h114))
      else $error("conversion length wrong");
   start_block_a: assert property ($rose(conv_busy) |-> !conv_done && adc_powered)
      else $error("busy rose while done set or unpowered");
   sample_len_a: assert property ($fell(sample_en) && conv_busy |->
      scnt == 10'h060 || scnt == 10'h048)
      else $error("sampling length wrong");
   sar_top_a: assert property ($fell(sample_en) && conv_busy |-> dac_voltage == SAR_TOP)
      else $error("first trial code wrong");
   chan_lock_a: assert property ($changed(analog_port) |->
      !$past(conv_busy) && !$past(conv_done))
      else $error("channel changed while busy or done");
   pd_off_a: assert property (power_down |=> !adc_powered)
      else $error("converter powered in power-down");
   abort_idle_a: assert property (!adc_powered && !$past(adc_powered) |->
      !conv_busy && !sample_en)
      else $error("conversion running while unpowered");
endmodule // sacc_top_assertions

`default_nettype wire

/* File: tb/tb_top.sv */
// Self-checking bench for the converter control block.
// Assumes the comparator model and a Wishbone classic master here.
`default_nettype none

module tb_top;
   timeunit 1ns;
   timeprecision 1ps;
   import sacc_pkg::*;
   logic ref_clk = 1'b0, rst = 1'b1; // Clock and reset
   logic cyc = 1'b0, stb = 1'b0, we = 1'b0, ack; // Bus control
   logic [11:0] adr = 12'h000; // Byte address
   logic [3:0] sel = 4'h0; // Byte lanes
   logic [31:0] dw = 32'h00000000, dr; // Write and read data
   logic idle = 1'b0, pd = 1'b0, pin = 1'b0, comp; // Chip state, pin
   logic [9:0] dac, r; // Trial code, expected result
   logic [2:0] port; // Selected channel
   logic smp, pwr, busy, done; // Status outputs
   logic [9:0] vin [8]; // Channel levels
   logic [31:0] seed = 32'h9ede92f9; // Generator state
   logic [7:0] q; // Read byte
   int mismatches = 0, cmp_count = 0;

   sacc_top dut (.ref_clk(ref_clk), .rst(rst), .wb_cyc_i(cyc), .wb_stb_i(stb),
      .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(dw), .wb_dat_o(dr),
      .wb_ack_o(ack), .idle_mode(idle), .power_down(pd), .ext_start_pin(pin),
      .comp_in(comp), .dac_voltage(dac), .analog_port(port), .sample_en(smp),
      .adc_powered(pwr), .conv_busy(busy), .conv_done(done));
   sacc_comp_model far (.ref_clk(ref_clk), .adc_powered(pwr), .dac_voltage(dac),
      .analog_port(port), .vin(vin), .comp_in(comp));

   // Free-running clock
   initial forever #20 ref_clk = ~ref_clk;

   // ----------------------------------------------------------
   // Helpers
   // ----------------------------------------------------------
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction

   // Approximation outcome, keeping a bit while input is above
   function automatic logic [9:0] sar_exp(input logic [9:0] v, input logic m8);
      logic [9:0] t;
      t = 10'h000;
      for (int b = 9; b >= (m8 ? 2 : 0); b--) begin
         if (v > (t | (10'h001 << b))) t = t | (10'h001 << b);
      end
      return t;
   endfunction

   task automatic finish_test();
      $display("comparisons %0d mismatches %0d", cmp_count, mismatches);
      if (mismatches == 0 && cmp_count > 0) begin
         $display("Finished cleanly");
      end else begin
         $display("Finished with errors");
      end
      $finish;
   endtask

   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         mismatches++;
         $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
      end
   endtask

   // One classic cycle, held until ack, then one idle cycle
   task automatic wb(input logic w, input logic [9:0] idx, input logic [7:0] d,
      output logic [7:0] rd);
      int n;
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= {idx, 2'b00};
      sel <= 4'h1;
      dw <= {24'h000000, d};
      do begin
         @(posedge ref_clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rd = dr[7:0];
      cyc <= 1'b0;
      stb <= 1'b0;
      @(posedge ref_clk);
      if (n == 20) begin
         mismatches++;
         finish_test();
      end
   endtask

   // Bounded wait for completion
   task automatic wait_done();
      int n;
      n = 0;
      while (done !== 1'b1 && n < 800) begin
         @(posedge ref_clk);
         n++;
      end
      if (n == 800) begin
         mismatches++;
         finish_test();
      end
   endtask

   // Pin low for two machine cycles, then high for three
   task automatic pulse();
      repeat (24) @(posedge ref_clk);
      pin <= 1'b1;
      repeat (36) @(posedge ref_clk);
      pin <= 1'b0;
   endtask

   // One conversion in the chosen mode with a refused restart during busy
   task automatic convert(input logic [2:0] ch, input logic m8, input logic clr);
      wb(1'b1, AUX_CTRL_IDX, {m8, 7'h00}, q);
      r = sar_exp(vin[ch], m8);
      wb(1'b1, ADC_CTRL_IDX, {5'h00, ch}, q);
      wb(1'b1, ADC_CTRL_IDX, {5'h01, ch}, q);
      repeat (40) @(posedge ref_clk);
      check(busy, 1'b1);
      wb(1'b1, ADC_CTRL_IDX, {5'h01, ch + 3'h1}, q);
      wb(1'b0, ADC_CTRL_IDX, 8'h00, q);
      check(q & 8'h3f, {5'h01, ch});
      wait_done();
      check(port, ch);
      wb(1'b0, RES_HIGH_IDX, 8'h00, q);
      check(q, r[9:2]);
      wb(1'b0, ADC_CTRL_IDX, 8'h00, q);
      check(q, {m8 ? 2'b00 : r[1:0], 3'b010, ch});
      if (clr) begin
         wb(1'b1, ADC_CTRL_IDX, {5'h02, ch}, q);
         check(done, 1'b1);
         wb(1'b1, ADC_CTRL_IDX, {5'h00, ch}, q);
         check(done, 1'b0);
      end
   endtask

   // ----------------------------------------------------------
   // Main sequence
   // ----------------------------------------------------------
   initial begin
      for (int c = 0; c < 8; c++) vin[c] = 10'h155;
      repeat (2) @(posedge ref_clk);
      rst <= 1'b0;
      @(posedge ref_clk);
      wb(1'b0, ADC_CTRL_IDX, 8'h00, q);
      check(q, CTRL_RESET);
      wb(1'b0, RES_HIGH_IDX, 8'h00, q);
      check(q, RES_HIGH_RESET);
      wb(1'b0, AUX_CTRL_IDX, 8'h00, q);
      check(q, AUX_RESET);
      wb(1'b1, 10'h0c8, 8'hff, q);
      wb(1'b0, 10'h0c8, 8'h00, q);
      check(q, 8'h00);
      for (int i = 0; i < 6; i++) begin
         for (int c = 0; c < 8; c++) begin
            seed = lfsr(seed);
            vin[c] <= seed[9:0];
         end
         convert(seed[12:10], i[0], 1'b1);
      end
      vin[0] <= 10'h000;
      vin[7] <= 10'h3ff;
      convert(3'h7, 1'b0, 1'b1);
      convert(3'h0, 1'b1, 1'b1);
      convert(3'h2, 1'b0, 1'b0);
      wb(1'b1, ADC_CTRL_IDX, 8'h1d, q);
      repeat (40) @(posedge ref_clk);
      check(busy, 1'b0);
      check(port, 3'h2);
      idle <= 1'b1;
      repeat (3) @(posedge ref_clk);
      check(pwr, 1'b0);
      check(done, 1'b1);
      idle <= 1'b0;
      wb(1'b1, ADC_CTRL_IDX, 8'h0a, q);
      repeat (40) @(posedge ref_clk);
      check(busy, 1'b1);
      pd <= 1'b1;
      repeat (3) @(posedge ref_clk);
      check(busy, 1'b0);
      pd <= 1'b0;
      wb(1'b1, AUX_CTRL_IDX, 8'h40, q);
      idle <= 1'b1;
      wb(1'b1, ADC_CTRL_IDX, 8'h0a, q);
      wait_done();
      check(pwr, 1'b1);
      idle <= 1'b0;
      wb(1'b1, ADC_CTRL_IDX, 8'h02, q);
      pulse();
      check(busy, 1'b0);
      wb(1'b1, ADC_CTRL_IDX, 8'h22, q);
      pulse();
      check(busy, 1'b1);
      wait_done();
      r = sar_exp(vin[2], 1'b0);
      wb(1'b0, RES_HIGH_IDX, 8'h00, q);
      check(q, r[9:2]);
      finish_test();
   end
endmodule // tb_top

bind sacc_top sacc_top_assertions chk (.ref_clk, .rst, .wb_cyc_i, .wb_stb_i,
   .wb_we_i, .wb_adr_i, .wb_sel_i, .wb_dat_i, .wb_ack_o, .power_down, .dac_voltage,
   .analog_port, .sample_en, .adc_powered, .conv_busy, .conv_done);

`default_nettype wire
